// file: shared/cag_pkg.sv
// cag_pkg: constants and types shared by the circular and reversed address generator
// assumes a 16-bit data space, 24-bit program space and a 32-bit avalon-mm register port
`default_nettype none
package cag_pkg;
	// register byte offsets on the avalon-mm port
	localparam logic [5:0] OFS_CIRC_REV_CTRL = 6'h00;
	localparam logic [5:0] OFS_REV_PIVOT     = 6'h04;
	localparam logic [5:0] OFS_X_START       = 6'h08;
	localparam logic [5:0] OFS_X_END         = 6'h0c;
	localparam logic [5:0] OFS_Y_START       = 6'h10;
	localparam logic [5:0] OFS_Y_END         = 6'h14;
	localparam logic [5:0] OFS_TABLE_PAGE    = 6'h18;
	localparam logic [5:0] OFS_WINDOW_PAGE   = 6'h1c;
	localparam logic [5:0] OFS_CORE_CTRL     = 6'h20;
	localparam logic [5:0] OFS_LAST_EA       = 6'h24;
	localparam logic [5:0] OFS_LAST_FLAGS    = 6'h28;

	// circular_reverse_control fields
	localparam int X_SEL_LSB    = 0;
	localparam int Y_SEL_LSB    = 4;
	localparam int REV_SEL_LSB  = 8;
	localparam int SEL_W        = 4;
	localparam int X_CIRC_EN    = 15;
	localparam int Y_CIRC_EN    = 14;
	// reverse_enable_and_pivot fields
	localparam int REV_EN       = 15;
	localparam int PIVOT_W      = 15;
	// core_control window enable bit
	localparam int WINDOW_EN    = 2;
	// table page bit that selects configuration memory
	localparam int TABLE_CFG    = 7;
	// select code meaning "no pointer"
	localparam logic [3:0] SEL_NONE = 4'hf;

	// reset values: all pointer selects disabled, all enables clear
	localparam logic [15:0] RST_CIRC_REV_CTRL = 16'h0fff;
	localparam logic [15:0] RST_REV_PIVOT     = 16'h0000;
	localparam logic [15:0] RST_BOUND         = 16'h0000;
	localparam logic [7:0]  RST_PAGE          = 8'h00;
	localparam logic [15:0] RST_CORE_CTRL     = 16'h0000;

	// largest circular buffer, in bytes (32k words)
	localparam logic [16:0] MAX_CIRC_BYTES = 17'h10000;

	// addressing mode of the current effective-address request
	typedef enum logic [1:0] {
		MODE_INDIRECT,
		MODE_POST_MOD,
		MODE_PRE_MOD,
		MODE_REG_OFFSET
	} cag_mode_t;
endpackage
`default_nettype wire

// file: hdl/cag_addr_gen.sv
// cag_addr_gen: effective-address post-processing for the 16-bit core
// circular correction, bit-reversed writes and program-space address forming
// assumes the pipeline presents one request per cycle, synchronous to clk_i
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
`timescale 1ns/10ps

// Function
// - one circular buffer each in x and y
// - 16-bit start and end per space
// - length from start/end difference, max 32k words
// - select 15 disables circular correction
// - x circular needs select not 15, bit15
// - y circular needs select not 15, bit14
// - y circular addresses keep lsb clear
// - bound compare catches overshooting steps
// - write back only for pre/post modify
// - power-of-two buffers check both bounds
// - bit reversal only x writes
// - reversal needs select, enable, pre/post increment
// - 15-bit pivot added bit-reversed to pointer
// - pivot scaled to bytes, lsb clear
// - reversal ignores offset; others get normal
// - reversal beats circular in x write only
// - pivot 8 visits 0,8,4,12... word order
// - table address is page concatenated with ea
// - window address is page concatenated with ea[14:0]
// - window accesses read-only, low word only
// - window mapping only when core bit2 set
module cag_addr_gen (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// avalon-mm register slave
	input  wire logic [5:0]            avs_address_i,
	input  wire logic                  avs_read_i,
	input  wire logic                  avs_write_i,
	input  wire logic [3:0]            avs_byteenable_i,
	input  wire logic [31:0]           avs_writedata_i,
	output logic      [31:0]           avs_readdata_o,
	output logic                       avs_waitrequest_o,
	// effective-address request from the pipeline
	input  wire logic                  req_valid_i,
	input  wire logic                  req_y_space_i,
	input  wire logic                  req_write_i,
	input  wire logic                  req_word_i,
	input  wire logic                  req_table_i,
	input  wire cag_pkg::cag_mode_t    req_mode_i,
	input  wire logic [3:0]            req_ptr_sel_i,
	input  wire logic [15:0]           req_ptr_value_i,
	input  wire logic [15:0]           req_offset_i,
	// data-space answer
	output logic                       ea_valid_o,
	output logic      [15:0]           ea_o,
	output logic                       ptr_wb_valid_o,
	output logic      [15:0]           ptr_wb_value_o,
	// program-space answer
	output logic                       prog_valid_o,
	output logic      [23:0]           prog_addr_o,
	output logic                       prog_config_o,
	output logic                       prog_low_word_o,
	output logic                       window_write_refused_o
);

	// whole module state, registered as one vector
	typedef struct packed {
		logic [15:0] circ_rev_ctrl;
		logic [15:0] rev_pivot;
		logic [15:0] x_start;
		logic [15:0] x_end;
		logic [15:0] y_start;
		logic [15:0] y_end;
		logic [7:0]  table_page;
		logic [7:0]  window_page;
		logic [15:0] core_ctrl;
		logic [15:0] last_ea;
		logic [3:0]  last_flags;
		logic [31:0] readdata;
		logic        waitrequest;
		logic        ea_valid;
		logic [15:0] ea;
		logic        wb_valid;
		logic [15:0] wb_value;
		logic        prog_valid;
		logic [23:0] prog_addr;
		logic        prog_config;
		logic        prog_low_word;
		logic        win_refused;
	} cag_state_t;

	cag_state_t state_reg;
	cag_state_t state_next;

	// 16-bit bit-order reversal
	function automatic logic [15:0] cag_rev16(input logic [15:0] v);
		logic [15:0] r;
		r = '0;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction

	// circular correction of one address against one buffer
	function automatic logic [15:0] cag_circ(input logic [15:0] addr, input logic [15:0] lo,
		input logic [15:0] hi, input logic incr);
		logic [16:0] len;
		logic        pow2;
		logic        chk_up;
		logic        chk_dn;
		logic [15:0] res;
		len = {1'b0, hi} - {1'b0, lo} + 17'h00001;
		if (len > cag_pkg::MAX_CIRC_BYTES) begin
			len = cag_pkg::MAX_CIRC_BYTES;
		end
		pow2   = ((len & (len - 17'h00001)) == 17'h00000);
		chk_up = pow2 | incr;
		chk_dn = pow2 | ~incr;
		res    = addr;
		// beyond, not only equal, so large steps still wrap
		if (chk_up && (addr > hi)) begin
			res = addr - len[15:0];
		end else if (chk_dn && (addr < lo)) begin
			res = addr + len[15:0];
		end
		return res;
	endfunction

	// request decode
	logic [3:0]  x_sel;
	logic [3:0]  y_sel;
	logic [3:0]  rev_sel;
	logic        x_circ_on;
	logic        y_circ_on;
	logic        rev_on;
	logic        modify_mode;
	logic        step_incr;
	logic [15:0] step_sum;
	logic [15:0] target;
	logic [15:0] rev_sum;
	logic [15:0] pivot_bytes;
	logic [15:0] corrected;
	logic        circ_hit;
	logic [15:0] ea_calc;
	logic [15:0] wb_calc;
	logic        window_hit;

	// pointer selection and mode qualification
	always_comb begin
		x_sel       = state_reg.circ_rev_ctrl[cag_pkg::X_SEL_LSB +: cag_pkg::SEL_W];
		y_sel       = state_reg.circ_rev_ctrl[cag_pkg::Y_SEL_LSB +: cag_pkg::SEL_W];
		rev_sel     = state_reg.circ_rev_ctrl[cag_pkg::REV_SEL_LSB +: cag_pkg::SEL_W];
		modify_mode = (req_mode_i == cag_pkg::MODE_PRE_MOD) || (req_mode_i == cag_pkg::MODE_POST_MOD);
		step_incr   = ~req_offset_i[15];
		// x select of 15 turns off both x read and x write correction
		x_circ_on   = (x_sel != cag_pkg::SEL_NONE) && state_reg.circ_rev_ctrl[cag_pkg::X_CIRC_EN]
			&& !req_y_space_i && (req_ptr_sel_i == x_sel);
		y_circ_on   = (y_sel != cag_pkg::SEL_NONE) && state_reg.circ_rev_ctrl[cag_pkg::Y_CIRC_EN]
			&& req_y_space_i && (req_ptr_sel_i == y_sel);
		// word writes through x with increment only; byte writes get normal addresses
		rev_on      = (rev_sel != cag_pkg::SEL_NONE) && state_reg.rev_pivot[cag_pkg::REV_EN]
			&& (req_ptr_sel_i == rev_sel) && modify_mode && step_incr
			&& !req_y_space_i && req_write_i && req_word_i;
		// reversal wins for the write generator only
		if (rev_on) begin
			x_circ_on = 1'b0;
		end
	end

	// address arithmetic
	always_comb begin
		step_sum    = req_ptr_value_i + req_offset_i;
		target      = (req_mode_i == cag_pkg::MODE_INDIRECT) ? req_ptr_value_i : step_sum;
		// pivot counts words, addresses count bytes
		pivot_bytes = {state_reg.rev_pivot[cag_pkg::PIVOT_W - 1:0], 1'b0};
		// reversed-carry add: carries run toward the lsb and fall off there
		rev_sum     = cag_rev16(cag_rev16(req_ptr_value_i) + cag_rev16(pivot_bytes));
		rev_sum[0]  = 1'b0;
		corrected   = target;
		if (x_circ_on) begin
			corrected = cag_circ(target, state_reg.x_start, state_reg.x_end, step_incr);
		end else if (y_circ_on) begin
			corrected = cag_circ(target, state_reg.y_start, state_reg.y_end, step_incr);
			corrected[0] = 1'b0;
		end
		circ_hit = (x_circ_on || y_circ_on) && (corrected != target);
		// effective address and pointer write-back per mode
		ea_calc = corrected;
		wb_calc = corrected;
		unique case (req_mode_i)
			cag_pkg::MODE_INDIRECT: begin
				ea_calc = corrected;
			end
			cag_pkg::MODE_POST_MOD: begin
				ea_calc = req_ptr_value_i;
			end
			cag_pkg::MODE_PRE_MOD: begin
				ea_calc = corrected;
			end
			cag_pkg::MODE_REG_OFFSET: begin
				ea_calc = corrected;
			end
		endcase
		if (rev_on) begin
			// the mode's own offset is ignored while reversing
			wb_calc = rev_sum;
			ea_calc = (req_mode_i == cag_pkg::MODE_PRE_MOD) ? rev_sum : {req_ptr_value_i[15:1], 1'b0};
		end
		window_hit = !req_table_i && ea_calc[15] && state_reg.core_ctrl[cag_pkg::WINDOW_EN];
	end

	// register file, bus handshake and answer registers
	always_comb begin
		state_next = state_reg;
		// one wait cycle per access, then one cycle with waitrequest low
		state_next.waitrequest = 1'b1;
		if ((avs_read_i || avs_write_i) && state_reg.waitrequest) begin
			state_next.waitrequest = 1'b0;
			state_next.readdata    = 32'h00000000;
			unique case (avs_address_i)
				cag_pkg::OFS_CIRC_REV_CTRL: state_next.readdata = {16'h0000, state_reg.circ_rev_ctrl};
				cag_pkg::OFS_REV_PIVOT:     state_next.readdata = {16'h0000, state_reg.rev_pivot};
				cag_pkg::OFS_X_START:       state_next.readdata = {16'h0000, state_reg.x_start};
				cag_pkg::OFS_X_END:         state_next.readdata = {16'h0000, state_reg.x_end};
				cag_pkg::OFS_Y_START:       state_next.readdata = {16'h0000, state_reg.y_start};
				cag_pkg::OFS_Y_END:         state_next.readdata = {16'h0000, state_reg.y_end};
				cag_pkg::OFS_TABLE_PAGE:    state_next.readdata = {24'h000000, state_reg.table_page};
				cag_pkg::OFS_WINDOW_PAGE:   state_next.readdata = {24'h000000, state_reg.window_page};
				cag_pkg::OFS_CORE_CTRL:     state_next.readdata = {16'h0000, state_reg.core_ctrl};
				cag_pkg::OFS_LAST_EA:       state_next.readdata = {16'h0000, state_reg.last_ea};
				cag_pkg::OFS_LAST_FLAGS:    state_next.readdata = {28'h0000000, state_reg.last_flags};
				default:                    state_next.readdata = 32'h00000000;
			endcase
		end
		// writes land at the edge where waitrequest is seen low
		if (avs_write_i && !state_reg.waitrequest) begin
			for (int b = 0; b < 2; b++) begin
				if (avs_byteenable_i[b]) begin
					unique case (avs_address_i)
						cag_pkg::OFS_CIRC_REV_CTRL: state_next.circ_rev_ctrl[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
						cag_pkg::OFS_REV_PIVOT:     state_next.rev_pivot[b*8 +: 8]     = avs_writedata_i[b*8 +: 8];
						cag_pkg::OFS_X_START:       state_next.x_start[b*8 +: 8]       = avs_writedata_i[b*8 +: 8];
						cag_pkg::OFS_X_END:         state_next.x_end[b*8 +: 8]         = avs_writedata_i[b*8 +: 8];
						cag_pkg::OFS_Y_START:       state_next.y_start[b*8 +: 8]       = avs_writedata_i[b*8 +: 8];
						cag_pkg::OFS_Y_END:         state_next.y_end[b*8 +: 8]         = avs_writedata_i[b*8 +: 8];
						cag_pkg::OFS_CORE_CTRL:     state_next.core_ctrl[b*8 +: 8]     = avs_writedata_i[b*8 +: 8];
						default: begin
						end
					endcase
				end
			end
			// page registers are one byte wide, lane 0 only
			if (avs_byteenable_i[0] && (avs_address_i == cag_pkg::OFS_TABLE_PAGE)) begin
				state_next.table_page = avs_writedata_i[7:0];
			end
			if (avs_byteenable_i[0] && (avs_address_i == cag_pkg::OFS_WINDOW_PAGE)) begin
				state_next.window_page = avs_writedata_i[7:0];
			end
		end

		// answer to the pipeline, one-cycle pulses one edge after the request
		state_next.ea_valid    = 1'b0;
		state_next.wb_valid    = 1'b0;
		state_next.prog_valid  = 1'b0;
		state_next.win_refused = 1'b0;
		if (req_valid_i) begin
			state_next.ea_valid   = 1'b1;
			state_next.ea         = ea_calc;
			state_next.wb_valid   = modify_mode;
			state_next.wb_value   = wb_calc;
			state_next.last_ea    = ea_calc;
			state_next.last_flags = {window_hit && req_write_i, window_hit, circ_hit, rev_on};
			if (req_table_i) begin
				// table access reaches user or configuration memory
				state_next.prog_valid    = 1'b1;
				state_next.prog_addr     = {state_reg.table_page, ea_calc};
				state_next.prog_config   = state_reg.table_page[cag_pkg::TABLE_CFG];
				state_next.prog_low_word = 1'b0;
			end else if (window_hit && req_write_i) begin
				// the window is read-only; the write is dropped
				state_next.win_refused   = 1'b1;
			end else if (window_hit) begin
				state_next.prog_valid    = 1'b1;
				state_next.prog_addr     = {1'b0, state_reg.window_page, ea_calc[14:0]};
				state_next.prog_config   = 1'b0;
				state_next.prog_low_word = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg               <= '0;
			state_reg.circ_rev_ctrl <= cag_pkg::RST_CIRC_REV_CTRL;
			state_reg.rev_pivot     <= cag_pkg::RST_REV_PIVOT;
			state_reg.x_start       <= cag_pkg::RST_BOUND;
			state_reg.x_end         <= cag_pkg::RST_BOUND;
			state_reg.y_start       <= cag_pkg::RST_BOUND;
			state_reg.y_end         <= cag_pkg::RST_BOUND;
			state_reg.table_page    <= cag_pkg::RST_PAGE;
			state_reg.window_page   <= cag_pkg::RST_PAGE;
			state_reg.core_ctrl     <= cag_pkg::RST_CORE_CTRL;
			state_reg.waitrequest   <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign avs_readdata_o         = state_reg.readdata;
	assign avs_waitrequest_o      = state_reg.waitrequest;
	assign ea_valid_o             = state_reg.ea_valid;
	assign ea_o                   = state_reg.ea;
	assign ptr_wb_valid_o         = state_reg.wb_valid;
	assign ptr_wb_value_o         = state_reg.wb_value;
	assign prog_valid_o           = state_reg.prog_valid;
	assign prog_addr_o            = state_reg.prog_addr;
	assign prog_config_o          = state_reg.prog_config;
	assign prog_low_word_o        = state_reg.prog_low_word;
	assign window_write_refused_o = state_reg.win_refused;

endmodule
`default_nettype wire

// file: test/cag_addr_gen_checker.sv
// cag_addr_gen_checker: port-level timing and address relations of the generator
// assumes it is bound into cag_addr_gen and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module cag_addr_gen_checker (
	input wire logic               clk_i,
	input wire logic               reset_n_i,
	input wire logic               avs_read_i,
	input wire logic               avs_write_i,
	input wire logic               avs_waitrequest_o,
	input wire logic               req_valid_i,
	input wire logic               req_write_i,
	input wire logic               req_table_i,
	input wire cag_pkg::cag_mode_t req_mode_i,
	input wire logic [3:0]         req_ptr_sel_i,
	input wire logic [15:0]        req_ptr_value_i,
	input wire logic [15:0]        req_offset_i,
	input wire logic               ea_valid_o,
	input wire logic [15:0]        ea_o,
	input wire logic               ptr_wb_valid_o,
	input wire logic [15:0]        ptr_wb_value_o,
	input wire logic               prog_valid_o,
	input wire logic [23:0]        prog_addr_o,
	input wire logic               prog_config_o,
	input wire logic               prog_low_word_o,
	input wire logic               window_write_refused_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// only pre and post modify may hand a pointer back
	wire logic mod_req = req_valid_i && (req_mode_i inside {cag_pkg::MODE_PRE_MOD, cag_pkg::MODE_POST_MOD});
	a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus access not answered next cycle");
	a_bus_one_low: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	a_ea_answer: assert property (req_valid_i |=> ea_valid_o)
		else $error("no address one cycle after request");
	a_ea_cause: assert property (ea_valid_o |-> $past(req_valid_i))
		else $error("address pulse without request");
	a_wb_modes: assert property (ptr_wb_valid_o == $past(mod_req))
		else $error("pointer writeback in wrong mode");
	a_plain_addr: assert property (req_valid_i && req_ptr_sel_i == cag_pkg::SEL_NONE |=>
		ea_o == (($past(req_mode_i) inside {cag_pkg::MODE_INDIRECT, cag_pkg::MODE_POST_MOD}) ?
		$past(req_ptr_value_i) : $past(req_ptr_value_i) + $past(req_offset_i)))
		else $error("unselected pointer address altered");
	a_table_addr: assert property (req_valid_i && req_table_i |=> prog_valid_o &&
		prog_addr_o[15:0] == ea_o && prog_config_o == prog_addr_o[23])
		else $error("table address not page and data address");
	a_window_addr: assert property (prog_valid_o && prog_low_word_o |->
		!prog_addr_o[23] && prog_addr_o[14:0] == ea_o[14:0] && ea_o[15])
		else $error("window address badly formed");
	a_window_ro: assert property (window_write_refused_o |->
		!prog_valid_o && $past(req_write_i) && !$past(req_table_i))
		else $error("window refusal without a window write");
	a_prog_cause: assert property (prog_valid_o |-> $past(req_valid_i) && ($past(req_table_i) || ea_o[15]))
		else $error("program access without table or upper address");
	c_window: cover property (prog_valid_o && prog_low_word_o);
	c_refused: cover property (window_write_refused_o);
	c_wb_run: cover property (ptr_wb_valid_o ##2 ptr_wb_valid_o);
endmodule
bind cag_addr_gen cag_addr_gen_checker u_chk (.*);
`default_nettype wire

// file: test/cag_core_model.sv
// cag_core_model: pipeline stand-in holding working pointers and issuing requests
// assumes the generator answers one cycle after each taken request
`timescale 1ns/10ps
`default_nettype none
module cag_core_model (
	// clock
	input  wire logic              clk_i,
	// pointer writeback
	input  wire logic              ptr_wb_valid_i,
	input  wire logic [15:0]       ptr_wb_value_i,
	// request to the generator
	output var logic               req_valid_o,
	output var logic               req_y_space_o,
	output var logic               req_write_o,
	output var logic               req_word_o,
	output var logic               req_table_o,
	output var cag_pkg::cag_mode_t req_mode_o,
	output var logic [3:0]         req_ptr_sel_o,
	output var logic [15:0]        req_ptr_value_o,
	output var logic [15:0]        req_offset_o
);
	logic [15:0] w[16];
	initial begin
		{req_valid_o, req_y_space_o, req_write_o, req_word_o, req_table_o, req_ptr_sel_o} = '0;
		{req_ptr_value_o, req_offset_o} = '0;
		req_mode_o = cag_pkg::MODE_INDIRECT;
		foreach (w[i]) w[i] = '0;
	end
	// writeback taken mid-cycle; each request is followed by one idle cycle so the next one sees it
	always @(negedge clk_i) if (ptr_wb_valid_i === 1'b1) w[req_ptr_sel_o] = ptr_wb_value_i;
	// frame and stack pointers never chosen for circular use
	task automatic issue(input logic y, wr, wd, t, input cag_pkg::cag_mode_t m, input logic [3:0] s,
		input logic [15:0] o);
		@(posedge clk_i);
		{req_valid_o, req_y_space_o, req_write_o, req_word_o, req_table_o} <= {1'b1, y, wr, wd, t};
		req_mode_o <= m;
		req_ptr_sel_o <= s;
		req_ptr_value_o <= w[s];
		req_offset_o <= o;
		// strobe dropped after one edge; a second edge would be a second request
		@(posedge clk_i);
		req_valid_o <= 1'b0;
	endtask
	// released fields scrambled so stale values are never trusted
	task automatic idle();
		@(posedge clk_i);
		req_valid_o <= 1'b0;
		req_ptr_value_o <= ~req_ptr_value_o;
		req_offset_o <= ~req_offset_o;
	endtask
endmodule
`default_nettype wire

// file: test/cag_addr_gen_tb.sv
// cag_addr_gen_tb: scoreboard bench for the address generator
// assumes the core model drives the pipeline side and the checker is bound
`timescale 1ns/10ps
`default_nettype none
module cag_addr_gen_tb;
	localparam cag_pkg::cag_mode_t IN = cag_pkg::MODE_INDIRECT, PO = cag_pkg::MODE_POST_MOD;
	localparam cag_pkg::cag_mode_t PR = cag_pkg::MODE_PRE_MOD, RO = cag_pkg::MODE_REG_OFFSET;
	logic clk_i = 1'b0, reset_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, wen = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic avs_waitrequest_o, req_valid_i, req_y_space_i, req_write_i, req_word_i, req_table_i, ea_valid_o;
	logic ptr_wb_valid_o, prog_valid_o, prog_config_o, prog_low_word_o, window_write_refused_o;
	cag_pkg::cag_mode_t req_mode_i, m;
	logic [3:0] req_ptr_sel_i;
	logic [15:0] req_ptr_value_i, req_offset_i, ea_o, ptr_wb_value_o, v, o;
	logic [23:0] prog_addr_o;
	logic [7:0] tpage = 8'h00, wpage = 8'h00;
	logic [31:0] bq[$];
	logic [60:0] eq[$];
	int n_mismatch = 0, tests_run = 0, cyc = 0, seq[16] = '{0, 8, 4, 12, 2, 10, 6, 14, 1, 9, 5, 13, 3, 11, 7, 15};
	always #2 clk_i = ~clk_i;
	cag_addr_gen u_dut (.*);
	cag_core_model u_core (.clk_i(clk_i), .ptr_wb_valid_i(ptr_wb_valid_o), .ptr_wb_value_i(ptr_wb_value_o),
		.req_valid_o(req_valid_i), .req_y_space_o(req_y_space_i), .req_write_o(req_write_i),
		.req_word_o(req_word_i), .req_table_o(req_table_i), .req_mode_o(req_mode_i),
		.req_ptr_sel_o(req_ptr_sel_i), .req_ptr_value_o(req_ptr_value_i), .req_offset_o(req_offset_i));
	task automatic chk(input logic [60:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		$display("counts: %0d compared, %0d wrong", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// pipeline is parked first, so no request repeats while the bus waits
	task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
		u_core.idle();
		{avs_address_i, avs_write_i, avs_read_i, avs_writedata_i} <= {a, w, !w, 16'h0, d};
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		{avs_read_i, avs_write_i} <= 2'b00;
		if (w && a == cag_pkg::OFS_TABLE_PAGE) tpage = d[7:0];
		if (w && a == cag_pkg::OFS_WINDOW_PAGE) wpage = d[7:0];
		if (w && a == cag_pkg::OFS_CORE_CTRL) wen = d[cag_pkg::WINDOW_EN];
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		bq.push_back({16'h0, e});
		bus(1'b0, a, 16'h0);
	endtask
	task automatic sw(input logic [3:0] s, input logic [15:0] p);
		u_core.idle();
		u_core.w[s] = p;
	endtask
	// expected program side: {valid, refused, low word, config, address}
	function automatic logic [27:0] pe(input logic t, w, input logic [15:0] ea);
		if (t) return {3'b100, tpage[7], tpage, ea};
		if (wen && ea[15]) return w ? 28'h4000000 : {5'b10100, wpage, ea[14:0]};
		return 28'h0;
	endfunction
	task automatic go(input logic y, w, wd, t, input cag_pkg::cag_mode_t md, input logic [3:0] s,
		input logic [15:0] of, ea, wb);
		logic b;
		b = md inside {PR, PO};
		eq.push_back({pe(t, w, ea), b, b ? wb : 16'h0, ea});
		u_core.issue(y, w, wd, t, md, s, of);
	endtask
	// scoreboards and hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			test_done();
		end
		if (!avs_waitrequest_o && avs_read_i) chk({29'h0, avs_readdata_o}, {29'h0, bq.pop_front()});
		if (ea_valid_o) chk({prog_valid_o, window_write_refused_o, prog_valid_o ? {prog_low_word_o, prog_config_o,
			prog_addr_o} : 26'h0, ptr_wb_valid_o, ptr_wb_valid_o ? ptr_wb_value_o : 16'h0, ea_o}, eq.pop_front());
	end
	initial begin
		void'($urandom(32'h5ffe));
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 12; i++) rd(6'(i * 4), i == 0 ? 16'h0fff : 16'h0000);
		for (int i = 0; i < 12; i++) begin
			v = 16'($urandom) & (i == 0 ? 16'hcfff : 16'hffff);
			bus(1'b1, 6'(i * 4), v);
			rd(6'(i * 4), (i < 6 || i == 8) ? v : (i < 8 ? {8'h0, v[7:0]} : 16'h0));
		end
		$display("test registers done");
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'hcfff);
		for (int i = 0; i < 24; i++) begin
			m = cag_pkg::cag_mode_t'($urandom_range(3));
			v = 16'($urandom);
			o = 16'($urandom);
			sw(4'hf, v);
			go(1'($urandom), 1'($urandom), 1'($urandom), '0, m, 4'hf, o, m inside {IN, PO} ? v : v + o, v + o);
		end
		$display("test unselected pointer done");
		bus(1'b1, cag_pkg::OFS_X_START, 16'h1000);
		bus(1'b1, cag_pkg::OFS_X_END, 16'h100f);
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'h8ff3);
		sw(4'h3, 16'h100a);
		go('0, '0, '1, '0, PO, 4'h3, 16'h0004, 16'h100a, 16'h100e);
		go('0, '0, '1, '0, PO, 4'h3, 16'h0004, 16'h100e, 16'h1002);
		go('0, '0, '1, '0, PR, 4'h3, 16'h0002, 16'h1004, 16'h1004);
		go('0, '0, '1, '0, RO, 4'h3, 16'h000c, 16'h1000, 16'h0000);
		go('0, '1, '1, '0, PR, 4'h3, 16'hfffa, 16'h100e, 16'h100e);
		sw(4'h3, 16'h0ff0);
		go('0, '0, '1, '0, PR, 4'h3, 16'h0002, 16'h1002, 16'h1002);
		sw(4'h4, 16'h100e);
		go('0, '0, '1, '0, PR, 4'h4, 16'h0004, 16'h1012, 16'h1012);
		sw(4'h3, 16'h100e);
		go('1, '0, '1, '0, PR, 4'h3, 16'h0004, 16'h1012, 16'h1012);
		bus(1'b1, cag_pkg::OFS_X_END, 16'h1009);
		sw(4'h3, 16'h1008);
		go('0, '0, '1, '0, PO, 4'h3, 16'h0004, 16'h1008, 16'h1002);
		sw(4'h3, 16'h0ff0);
		go('0, '0, '1, '0, PR, 4'h3, 16'h0002, 16'h0ff2, 16'h0ff2);
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'h0ff3);
		sw(4'h3, 16'h1008);
		go('0, '0, '1, '0, PR, 4'h3, 16'h0004, 16'h100c, 16'h100c);
		bus(1'b1, cag_pkg::OFS_Y_START, 16'h2000);
		bus(1'b1, cag_pkg::OFS_Y_END, 16'h2007);
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'h4f5f);
		sw(4'h5, 16'h2006);
		go('1, '0, '1, '0, PR, 4'h5, 16'h0003, 16'h2000, 16'h2000);
		$display("test circular done");
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'h06ff);
		bus(1'b1, cag_pkg::OFS_REV_PIVOT, 16'h8008);
		sw(4'h6, 16'h0000);
		for (int k = 0; k < 16; k++) go('0, '1, '1, '0, PO, 4'h6, 16'($urandom) & 16'h7ffe,
			16'(seq[k] * 2), 16'(seq[(k + 1) % 16] * 2));
		go('0, '1, '1, '0, PR, 4'h6, 16'h0002, 16'h0010, 16'h0010);
		go('0, '1, '0, '0, PR, 4'h6, 16'h0001, 16'h0011, 16'h0011);
		go('0, '0, '1, '0, PO, 4'h6, 16'h0002, 16'h0011, 16'h0013);
		bus(1'b1, cag_pkg::OFS_REV_PIVOT, 16'h0008);
		sw(4'h6, 16'h0000);
		go('0, '1, '1, '0, PR, 4'h6, 16'h0002, 16'h0002, 16'h0002);
		bus(1'b1, cag_pkg::OFS_X_START, 16'h0000);
		bus(1'b1, cag_pkg::OFS_X_END, 16'h001f);
		bus(1'b1, cag_pkg::OFS_REV_PIVOT, 16'h8008);
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'h86f6);
		sw(4'h6, 16'h001e);
		go('0, '0, '1, '0, PO, 4'h6, 16'h0004, 16'h001e, 16'h0002);
		sw(4'h6, 16'h000c);
		go('0, '1, '1, '0, PO, 4'h6, 16'h0002, 16'h000c, 16'h001c);
		$display("test reversed done");
		bus(1'b1, cag_pkg::OFS_CIRC_REV_CTRL, 16'h0fff);
		bus(1'b1, cag_pkg::OFS_TABLE_PAGE, 16'h0085);
		bus(1'b1, cag_pkg::OFS_WINDOW_PAGE, 16'h003c);
		bus(1'b1, cag_pkg::OFS_CORE_CTRL, 16'h0000);
		sw(4'hf, 16'h1234);
		go('0, '0, '1, '1, IN, 4'hf, 16'h0000, 16'h1234, 16'h0000);
		sw(4'hf, 16'h9abc);
		go('0, '0, '1, '0, IN, 4'hf, 16'h0000, 16'h9abc, 16'h0000);
		bus(1'b1, cag_pkg::OFS_CORE_CTRL, 16'h0004);
		go('0, '0, '1, '0, IN, 4'hf, 16'h0000, 16'h9abc, 16'h0000);
		go('0, '1, '1, '0, IN, 4'hf, 16'h0000, 16'h9abc, 16'h0000);
		go('0, '0, '1, '1, IN, 4'hf, 16'h0000, 16'h9abc, 16'h0000);
		rd(cag_pkg::OFS_LAST_EA, 16'h9abc);
		// let the scoreboard take the last answer before the run ends
		repeat (2) @(posedge clk_i);
		$display("test program space done");
		test_done();
	end
endmodule
`default_nettype wire
